//--- design/welc_pkg.sv
// Package for the wakeup and event line controller: register map, widths, types.
// Assumes a single 100 MHz clock domain and a plain one-cycle register port.
package welc_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_LINES = 32;
  localparam int unsigned NUM_CFG = 30;
  localparam int unsigned NUM_GPIO = 24;

  // ***************************************************************
  // Register offsets (byte addresses)
  // ***************************************************************
  localparam logic [7:0] OFS_RISE_TRIG = 8'h00;
  localparam logic [7:0] OFS_FALL_TRIG = 8'h04;
  localparam logic [7:0] OFS_SW_TRIG = 8'h08;
  localparam logic [7:0] OFS_RISE_PEND = 8'h0c;
  localparam logic [7:0] OFS_FALL_PEND = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_EVT_MASK = 8'h18;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [29:0] RST_TRIG = 30'h0;
  localparam logic [29:0] RST_PEND = 30'h0;
  localparam logic [31:0] RST_MASK = 32'h0;
  localparam logic [31:0] RST_RDATA = 32'h0;

  // ***************************************************************
  // Line positions
  // ***************************************************************
  localparam int unsigned LINE_LVD = 24;
  localparam int unsigned LINE_RTC_ALARM = 30;
  localparam int unsigned LINE_RTC_WUT = 31;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } welc_bus_req_t;

  typedef struct packed {
    logic rtc_wakeup_timer;
    logic rtc_alarm;
    logic over_temperature;
    logic charge_end;
    logic charge_ok;
    logic comparator_one;
    logic comparator_zero;
    logic low_voltage_detector;
    logic [23:0] gpio;
  } welc_src_t;

endpackage

//--- design/welc_edge_detect.sv
// Two-stage synchroniser and edge detector for every input line.
// Assumes inputs may be asynchronous; edges come out as one-cycle pulses.
`timescale 1ns/1ns
module welc_edge_detect
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] line_in,
  output logic [31:0] rise_pulse,
  output logic [31:0] fall_pulse
);

  logic [31:0] sync_a;
  logic [31:0] sync_b;
  logic [31:0] last;

  // ***************************************************************
  // Synchroniser and history
  // ***************************************************************
  // First stage feeds only the second stage, to keep metastability contained
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a <= 32'h0;
      sync_b <= 32'h0;
      last <= 32'h0;
    end
    else
    begin
      sync_a <= line_in;
      sync_b <= sync_a;
      last <= sync_b;
    end
  end

  assign rise_pulse = sync_b & ~last;
  assign fall_pulse = ~sync_b & last;

endmodule

//--- design/welc_top.sv
// Wakeup and event line controller: 30 configurable lines, 2 direct lines.
// Assumes a plain register port whose read data is expected one cycle later.
// Notes on behaviour
// - Enabled line event raises a wakeup request.
// - Every wakeup request can end stop mode.
// - Interrupts and events also work in run.
// - Any enabled line, either kind, wakes system.
// - Configurable lines: rising/falling enables, software trigger.
// - Separate rising and falling pending flags.
// - Per-line interrupt and event mask bits.
// - Direct lines trigger on rising edge only.
// - Direct lines have no pending flag here.
// - No software trigger for direct lines.
// - Direct masks gate wakeup and event only.
// - Pending flag holds until software clears it.
// - Configurable interrupts go to cpu_interrupt_controller.
// - One CPU event output to receive-event input.
// - Wakeup outputs go to power_management_unit.
// - Lines 0 to 23 come from GPIO pins.
// - Lines 24-29: detector, comparators, charge, temperature.
// - Line 30 RTC alarm, 31 RTC wakeup timer.
// - Software trigger sets rising pending, ignores enables.
// - Pending set only when interrupt unmasked.
// - All enabled events ORed into one output.
// - Rising and falling enables reset disabled.
`timescale 1ns/1ns
module welc_top
(
  input wire logic clk,
  input wire logic rst,
  input wire welc_pkg::welc_bus_req_t bus_req,
  output logic [31:0] rdata,
  input wire welc_pkg::welc_src_t src,
  output logic [29:0] irq,
  output logic cpu_event,
  output logic [31:0] wakeup_req
);

  logic [29:0] rise_trig;
  logic [29:0] fall_trig;
  logic [29:0] rise_pend;
  logic [29:0] fall_pend;
  logic [31:0] int_mask;
  logic [31:0] evt_mask;
  logic [31:0] line_in;
  logic [31:0] rise_pulse;
  logic [31:0] fall_pulse;
  logic [29:0] sw_pulse;
  logic [29:0] cfg_hit;
  logic [29:0] rise_set;
  logic [29:0] fall_set;
  logic [31:0] line_event;
  logic [31:0] next_wakeup;
  logic [31:0] next_rdata;
  logic wr_rise_pend;
  logic wr_fall_pend;

  // ***************************************************************
  // Line sources
  // ***************************************************************
  assign line_in = {src.rtc_wakeup_timer, src.rtc_alarm,
                    src.over_temperature, src.charge_end, src.charge_ok,
                    src.comparator_one, src.comparator_zero,
                    src.low_voltage_detector,
                    src.gpio};

  welc_edge_detect u_edge
  (
    .clk(clk),
    .rst(rst),
    .line_in(line_in),
    .rise_pulse(rise_pulse),
    .fall_pulse(fall_pulse)
  );

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rise_trig <= welc_pkg::RST_TRIG;
      fall_trig <= welc_pkg::RST_TRIG;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == welc_pkg::OFS_RISE_TRIG)
        rise_trig <= bus_req.wdata[29:0];
      if (bus_req.addr == welc_pkg::OFS_FALL_TRIG)
        fall_trig <= bus_req.wdata[29:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_mask <= welc_pkg::RST_MASK;
      evt_mask <= welc_pkg::RST_MASK;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == welc_pkg::OFS_INT_MASK)
        int_mask <= bus_req.wdata;
      if (bus_req.addr == welc_pkg::OFS_EVT_MASK)
        evt_mask <= bus_req.wdata;
    end
  end

  // Software trigger is a write-only pulse; only configurable bits exist
  assign sw_pulse = (bus_req.wr && bus_req.addr == welc_pkg::OFS_SW_TRIG) ?
                    bus_req.wdata[29:0] : 30'h0;

  // ***************************************************************
  // Edge qualification
  // ***************************************************************
  assign rise_set = (rise_pulse[29:0] & rise_trig) | sw_pulse;
  assign fall_set = fall_pulse[29:0] & fall_trig;
  assign cfg_hit = rise_set | fall_set;
  // Direct lines use only the synchronised rising edge
  assign line_event = {rise_pulse[31:30], cfg_hit};

  assign wr_rise_pend = bus_req.wr && bus_req.addr == welc_pkg::OFS_RISE_PEND;
  assign wr_fall_pend = bus_req.wr && bus_req.addr == welc_pkg::OFS_FALL_PEND;

  // ***************************************************************
  // Pending flags, configurable lines only
  // ***************************************************************
  // Write one to clear; a new edge in the same cycle wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < 30; gi++)
    begin : g_pend
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          rise_pend[gi] <= 1'b0;
          fall_pend[gi] <= 1'b0;
        end
        else
        begin
          if (rise_set[gi] && int_mask[gi])
            rise_pend[gi] <= 1'b1;
          else if (wr_rise_pend && bus_req.wdata[gi])
            rise_pend[gi] <= 1'b0;
          if (fall_set[gi] && int_mask[gi])
            fall_pend[gi] <= 1'b1;
          else if (wr_fall_pend && bus_req.wdata[gi])
            fall_pend[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // Outputs to interrupt controller, CPU and power management
  // ***************************************************************
  // Direct lines get no request here; their peripheral interrupts the CPU
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 30'h0;
    else
      irq <= (rise_pend | fall_pend) & int_mask[29:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cpu_event <= 1'b0;
    else
      cpu_event <= |(line_event & evt_mask);
  end

  // Configurable wakeups hold with the interrupt; event-only ones are pulses
  assign next_wakeup = {line_event[31:30] & (int_mask[31:30] | evt_mask[31:30]),
                        ((rise_pend | fall_pend) & int_mask[29:0]) |
                        (cfg_hit & (int_mask[29:0] | evt_mask[29:0]))};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wakeup_req <= 32'h0;
    else
      wakeup_req <= next_wakeup;
  end

  // ***************************************************************
  // Read port
  // ***************************************************************
  always_comb
  begin
    next_rdata = 32'h0;
    case (bus_req.addr)
      welc_pkg::OFS_RISE_TRIG: next_rdata = {2'h0, rise_trig};
      welc_pkg::OFS_FALL_TRIG: next_rdata = {2'h0, fall_trig};
      welc_pkg::OFS_RISE_PEND: next_rdata = {2'h0, rise_pend};
      welc_pkg::OFS_FALL_PEND: next_rdata = {2'h0, fall_pend};
      welc_pkg::OFS_INT_MASK: next_rdata = int_mask;
      welc_pkg::OFS_EVT_MASK: next_rdata = evt_mask;
      default: next_rdata = 32'h0;
    endcase
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= welc_pkg::RST_RDATA;
    else if (bus_req.rd)
      rdata <= next_rdata;
    else
      rdata <= 32'h0;
  end

endmodule

//--- tb/welc_checker.sv
// Port checker for the wakeup and event line controller.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ns
module welc_checker
(
  input wire logic clk,
  input wire logic rst,
  input wire welc_pkg::welc_bus_req_t bus_req,
  input wire logic [31:0] rdata,
  input wire welc_pkg::welc_src_t src,
  input wire logic [29:0] irq,
  input wire logic cpu_event,
  input wire logic [31:0] wakeup_req
);
  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_SW_READ_ZERO: assert property (bus_req.rd && bus_req.addr == 8'h08
    |=> rdata == 32'h0) else $error("software trigger read not zero");
  AST_TRIG_RSVD: assert property (bus_req.rd &&
    (bus_req.addr inside {8'h00, 8'h04, 8'h0c, 8'h10}) |=> rdata[31:30] == 2'h0)
    else $error("reserved bits of line register read set");
  // Window tolerates the sync depth but still rejects a falling edge
  AST_ALARM_RISE: assert property (wakeup_req[30] |->
    $past(src.rtc_alarm, 2) && !$past(src.rtc_alarm, 6))
    else $error("line 30 wakeup without rising edge");
  AST_TIMER_RISE: assert property (wakeup_req[31] |->
    $past(src.rtc_wakeup_timer, 2) && !$past(src.rtc_wakeup_timer, 6))
    else $error("line 31 wakeup without rising edge");
  AST_DIRECT_PULSE: assert property (wakeup_req[31:30] != 2'h0 |=>
    (wakeup_req[31:30] & $past(wakeup_req[31:30])) == 2'h0)
    else $error("direct wakeup longer than one cycle");
  AST_EVENT_WAKES: assert property (cpu_event |-> wakeup_req != 32'h0)
    else $error("cpu event without wakeup");
  AST_IRQ_WAKES: assert property (((irq & $past(irq)) & ~wakeup_req[29:0]) == 30'h0)
    else $error("held interrupt without wakeup");
  AST_IRQ_HOLD: assert property (|($past(irq) & ~irq) |->
    $past(bus_req.wr, 2) || $past(bus_req.wr, 3))
    else $error("interrupt dropped without software write");
  COV_EVENT: cover property (cpu_event);
  COV_DIRECT: cover property (wakeup_req[31:30] != 2'h0);
  COV_IRQ_CLEAR: cover property (|($past(irq) & ~irq));
endmodule

bind welc_top welc_checker i_welc_checker (.clk(clk), .rst(rst), .bus_req(bus_req),
  .rdata(rdata), .src(src), .irq(irq), .cpu_event(cpu_event), .wakeup_req(wakeup_req));

//--- tb/welc_src_model.sv
// Far side: line sources and the CPU receive-event input.
// Assumes the bench sets line levels; counts event pulses seen.
`timescale 1ns/1ns
module welc_src_model
(
  input wire logic clk,
  input wire logic [31:0] lines,
  input wire logic cpu_event,
  output welc_pkg::welc_src_t src = 32'h0,
  output logic [7:0] rx_count = 8'h00
);
  // Sources change just after an edge, as registered peripherals do
  // Direct sources hold their own flag; software clears it there, not here
  always_ff @(posedge clk)
  begin
    src <= welc_pkg::welc_src_t'(lines);
  end
  always_ff @(posedge clk)
  begin
    rx_count <= rx_count + {7'h00, cpu_event};
  end
endmodule

//--- tb/tb_welc_top.sv
// Bench for the line controller: table of line cases, then hand tests.
// Assumes the source model feeds the lines and counts CPU events.
`timescale 1ns/1ns
module tb_welc_top;
  typedef struct packed {
    logic [4:0] ln;
    logic [8:0] f;
  } welc_row_t;
  // Flags: rise_en fall_en int_mask evt_mask level | rpend fpend event wakeup
  localparam welc_row_t ROWS [8] = '{{5'd3, 9'b101011001}, {5'd5, 9'b011100111},
    {5'd24, 9'b110110011}, {5'd29, 9'b001110000}, {5'd30, 9'b000110011},
    {5'd31, 9'b001000000}, {5'd31, 9'b001010001}, {5'd26, 9'b100010000}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  welc_pkg::welc_bus_req_t bus_req = 42'h0;
  logic [31:0] lines = 32'h0;
  welc_pkg::welc_src_t src;
  logic [31:0] rdata;
  logic [31:0] wakeup_req;
  logic [29:0] irq;
  logic cpu_event;
  logic [7:0] rx_count;
  int num_errors = 0;
  int compares = 0;

  always #5 clk = ~clk;

  welc_top i_welc_top (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .src(src),
    .irq(irq), .cpu_event(cpu_event), .wakeup_req(wakeup_req));
  welc_src_model i_welc_src_model (.clk(clk), .lines(lines), .cpu_event(cpu_event),
    .src(src), .rx_count(rx_count));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One idle cycle after each access keeps a strobe from being driven twice at an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    chk(nm, exp, rdata);
  endtask

  task automatic run_row(input welc_row_t r);
    logic [31:0] b;
    logic wk;
    logic [7:0] c0;
    b = 32'h1 << r.ln;
    wk = 1'b0;
    @(posedge clk);
    lines[r.ln] <= ~r.f[4];
    repeat (6) @(posedge clk);
    wr(welc_pkg::OFS_RISE_PEND, 32'hffffffff);
    wr(welc_pkg::OFS_FALL_PEND, 32'hffffffff);
    wr(welc_pkg::OFS_RISE_TRIG, r.f[8] ? b : 32'h0);
    wr(welc_pkg::OFS_FALL_TRIG, r.f[7] ? b : 32'h0);
    wr(welc_pkg::OFS_INT_MASK, r.f[6] ? b : 32'h0);
    wr(welc_pkg::OFS_EVT_MASK, r.f[5] ? b : 32'h0);
    c0 = rx_count;
    lines[r.ln] <= r.f[4];
    repeat (10)
    begin
      @(negedge clk);
      wk = wk | wakeup_req[r.ln];
    end
    chk("events", {31'h0, r.f[1]}, 32'(rx_count - c0));
    chk("wakeup", {31'h0, r.f[0]}, {31'h0, wk});
    rd(welc_pkg::OFS_RISE_PEND, r.f[3] ? b : 32'h0, "rise_pend");
    rd(welc_pkg::OFS_FALL_PEND, r.f[2] ? b : 32'h0, "fall_pend");
    chk("irq", (r.f[3] | r.f[2]) ? b : 32'h0, {2'h0, irq});
  endtask

  task automatic complete_run();
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      rd(8'(4 * i), 32'h0, "reset value");
    end
    foreach (ROWS[i])
    begin
      run_row(ROWS[i]);
    end
    // Software trigger with the rising enable off, direct bits set too
    wr(welc_pkg::OFS_RISE_TRIG, 32'h0);
    wr(welc_pkg::OFS_INT_MASK, 32'hc0000080);
    wr(welc_pkg::OFS_SW_TRIG, 32'hc0000080);
    repeat (2) @(negedge clk);
    chk("direct wakeup", 32'h0, {30'h0, wakeup_req[31:30]});
    rd(welc_pkg::OFS_RISE_PEND, 32'h80, "sw pend");
    rd(welc_pkg::OFS_SW_TRIG, 32'h0, "sw read");
    chk("sw irq", 32'h80, {2'h0, irq});
    wr(welc_pkg::OFS_RISE_PEND, 32'h80);
    repeat (3) @(negedge clk);
    chk("cleared irq", 32'h0, {2'h0, irq});
    wr(welc_pkg::OFS_FALL_TRIG, 32'hffffffff);
    rd(welc_pkg::OFS_FALL_TRIG, 32'h3fffffff, "fall enables");
    rd(8'h40, 32'h0, "unmapped");
    complete_run();
  end
endmodule
